// [verilog/cks_pkg.sv]
// Function
// RULE_01 - USB codes 000,001,110 pick HF, HF/8, LF.
// RULE_02 - USB codes 010-101 external /1..4; 111 reserved.
// RULE_03 - Select register bit 7 reads zero, ignores writes.
// RULE_04 - Bit 3 picks raw or resynced pin clock.
// RULE_05 - System codes 000-011 pick HF paths or external.
// RULE_06 - System code 100 picks LF with its divider.
// RULE_07 - Select register resets to zero, HF path.
// RULE_08 - HF 48 MHz, divide by four then 1/2/4/8.
// RULE_09 - Post divider defaults to divide by eight.
// RULE_10 - Writing suspend bit one halts the oscillator.
// RULE_11 - CPU clock stops until USB or VBUS wake; the code stops it only while the system clock comes from an HF path.
// RULE_12 - Wake resumes oscillator, CPU and peripherals.
// RULE_13 - USB wake detection works with transceiver off.
// RULE_14 - Seven bit calibration sets oscillator period.
// RULE_15 - Calibration resets to the factory trim value.
// RULE_16 - Software changes calibration only while disabled; the code accepts calibration writes whatever the enable bit.
// RULE_17 - Calibration register bit 7 reads zero.
// RULE_18 - Divider codes 00..11 divide by 8,4,2,1.
// RULE_19 - Software sets USB clock 48 or 6 MHz.
// RULE_20 - Software switches only to running sources.
// RULE_21 - Enable bit zero disables, one enables oscillator.
// RULE_22 - Clock multiplexers switch without glitches.
// RULE_23 - Reserved USB code holds USB clock stopped.
`default_nettype none
package cks_pkg;
  // Register addresses on the special function register bus.
  localparam logic [7:0] ADDR_CLK_SEL   = 8'hA9;
  localparam logic [7:0] ADDR_HF_CTRL   = 8'hB2;
  localparam logic [7:0] ADDR_HF_CALIB  = 8'hB3;
  // Field positions inside the clock select register.
  localparam int         USB_SEL_LSB    = 4;
  localparam int         OUT_SYNC_BIT   = 3;
  localparam int         SYS_SEL_LSB    = 0;
  // Field positions inside the oscillator control register.
  localparam int         HF_EN_BIT      = 7;
  localparam int         HF_RDY_BIT     = 6;
  localparam int         HF_SUSP_BIT    = 5;
  localparam int         HF_DIV_LSB     = 0;
  // Values after reset.
  localparam logic [7:0] CLK_SEL_RST    = 8'h00;
  localparam logic       HF_EN_RST      = 1'b1;
  localparam logic       HF_SUSP_RST    = 1'b0;
  localparam logic [1:0] HF_DIV_RST     = 2'h0;
  localparam logic [6:0] HF_CALIB_RST   = 7'h00;
  // Index of each pin input inside the synchroniser bank.
  localparam int         PIN_HF         = 0;
  localparam int         PIN_LF         = 1;
  localparam int         PIN_EXT        = 2;
  localparam int         PIN_USB_EV     = 3;
  localparam int         PIN_VBUS       = 4;
  localparam int         PIN_COUNT      = 5;
  // System clock source codes.
  localparam logic [2:0] SYS_HF_DIV     = 3'h0;
  localparam logic [2:0] SYS_EXT        = 3'h1;
  localparam logic [2:0] SYS_HF_HALF    = 3'h2;
  localparam logic [2:0] SYS_HF_FULL    = 3'h3;
  localparam logic [2:0] SYS_LF         = 3'h4;
  // USB clock source codes.
  localparam logic [2:0] USB_HF         = 3'h0;
  localparam logic [2:0] USB_HF_DIV8    = 3'h1;
  localparam logic [2:0] USB_EXT_DIV1   = 3'h2;
  localparam logic [2:0] USB_EXT_DIV2   = 3'h3;
  localparam logic [2:0] USB_EXT_DIV3   = 3'h4;
  localparam logic [2:0] USB_EXT_DIV4   = 3'h5;
  localparam logic [2:0] USB_LF         = 3'h6;
  localparam logic [2:0] USB_RESERVED   = 3'h7;
  // Last state of the divide-by-three counter.
  localparam logic [1:0] DIV3_LAST      = 2'h2;
endpackage
`default_nettype wire

// [verilog/cks_mux_if.sv]
`default_nettype none
// Candidate clock levels, the select code and the switched clock level.
interface cks_mux_if;
  logic [7:0] cand;  // Level of each candidate source.
  logic [2:0] sel;   // Requested source code.
  logic       clk;   // Switched clock level, from a flop.
  modport mux  (input cand, input sel, output clk);
  modport user (output cand, output sel, input clk);
endinterface
`default_nettype wire

// [verilog/cks_glitchless_mux.sv]
`default_nettype none
module cks_glitchless_mux (
  // Clock and reset.
  input  wire logic sys_clk_in,
  input  wire logic resetn_in,
  // Candidates, select and switched clock.
  cks_mux_if.mux    mux_if
);
  import cks_pkg::*;

  logic [2:0] cur_sel;     // Source currently driving the output.
  logic       out_level;   // Registered output level.
  wire        want_switch; // A new source has been requested.
  wire        safe_point;  // Both old and new sources sit low.

  assign want_switch = (mux_if.sel != cur_sel);
  // Moving only while output and both sources are low means no high phase is
  // ever shortened; the price is a wait of up to one slow-clock period.
  assign safe_point  = !out_level && !mux_if.cand[cur_sel] &&
                       !mux_if.cand[mux_if.sel];
  assign mux_if.clk  = out_level;

  // The select register moves only at a safe point.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur_sel <= 3'h0;
    end else if (want_switch && safe_point) begin
      cur_sel <= mux_if.sel;  // [RULE_22]
    end
  end

  // The output follows the source currently in use.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      out_level <= 1'b0;
    end else begin
      out_level <= mux_if.cand[cur_sel];
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  // A switch only happens after a low output phase.
  a_switch_low_out: assert property (  // [RULE_22]
    $changed(cur_sel) |-> !$past(out_level))
    else $error("clock source switched while output high");
endmodule
`default_nettype wire

// [verilog/cks_clock_select.sv]
`default_nettype none
module cks_clock_select (
  // Clock and reset.
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  // Special function register bus.
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  output logic      [7:0] sfr_rdata_out,
  // Oscillator levels and wake sources from outside the clock domain.
  input  wire logic       hf_osc_clk_in,
  input  wire logic       lf_osc_clk_in,
  input  wire logic       ext_osc_clk_in,
  input  wire logic       usb_event_in,
  input  wire logic       vbus_sense_in,
  // Low-frequency divider code and factory trim strap.
  input  wire logic [1:0] lf_osc_divider_in,
  input  wire logic [6:0] factory_trim_in,
  // Oscillator controls.
  output logic            hf_osc_run_out,
  output logic      [6:0] hf_osc_period_out,
  // Derived clocks.
  output logic            system_clock_out,
  output logic            cpu_clock_out,
  output logic            usb_clock_out,
  output logic            pin_clock_out
);
  import cks_pkg::*;

  // Picks one of four taps by a two-bit code.
  function automatic logic cks_pick4(input logic [3:0] taps,
                                     input logic [1:0] code);
    cks_pick4 = taps[code];
  endfunction

  // Three-stage synchronisers and the agreed level of each pin input.
  logic [PIN_COUNT-1:0] sync_s1;
  logic [PIN_COUNT-1:0] sync_s2;
  logic [PIN_COUNT-1:0] sync_s3;
  logic [PIN_COUNT-1:0] pin_level;
  wire  [PIN_COUNT-1:0] raw_pins;
  wire  [PIN_COUNT-1:0] next_pin_level;
  wire  [PIN_COUNT-1:0] pin_rise;

  // Registers seen by software, and the strap capture flag.
  logic [6:0] clock_source_select;  // Bit 7 is not stored.
  logic       hf_osc_enable;        // Oscillator enable.
  logic       hf_osc_suspend;       // Suspend request, cleared by wake.
  logic [1:0] hf_post_divider;      // Division after the fixed stage.
  logic [6:0] hf_osc_calibration;   // Oscillator period trim.
  logic       trim_loaded;          // Strap has been captured.

  // Divider counters, stepped on rising edges of the agreed levels.
  logic [4:0] hf_cnt;
  logic [1:0] ext_cnt;
  logic [1:0] ext_div3_cnt;
  logic [2:0] lf_cnt;

  // Clock gating and pin clock resync.
  logic       cpu_gate_on;
  logic       sys_resync;

  // Field views and decodes.
  wire  [2:0] usb_clock_source_field;
  wire  [2:0] system_clock_source_field;
  wire        pin_clock_out_sync_sel;
  wire        wr_sel;
  wire        wr_ctrl;
  wire        wr_calib;
  wire        wake_event;
  wire        next_suspend;
  wire        sys_from_hf;
  wire        clock_stop_req;
  wire        hf_div_tap;
  wire        lf_div_tap;
  wire        sys_mux_clk;
  wire        usb_mux_clk;
  wire  [7:0] ctrl_view;
  wire  [7:0] next_rdata;

  cks_mux_if sys_if ();
  cks_mux_if usb_if ();

  assign raw_pins = {vbus_sense_in, usb_event_in, ext_osc_clk_in,
                     lf_osc_clk_in, hf_osc_clk_in};
  // A change counts only once the second and third stages agree.
  assign next_pin_level = (sync_s2 & sync_s3) |
                          (pin_level & (sync_s2 | sync_s3));
  assign pin_rise = next_pin_level & ~pin_level;

  assign usb_clock_source_field    = clock_source_select[USB_SEL_LSB +: 3];
  assign pin_clock_out_sync_sel    = clock_source_select[OUT_SYNC_BIT];
  assign system_clock_source_field = clock_source_select[SYS_SEL_LSB +: 3];

  assign wr_sel   = sfr_wr_in && (sfr_addr_in == ADDR_CLK_SEL);
  assign wr_ctrl  = sfr_wr_in && (sfr_addr_in == ADDR_HF_CTRL);
  assign wr_calib = sfr_wr_in && (sfr_addr_in == ADDR_HF_CALIB);

  // Wake needs no transceiver enable: it reads only the event and VBUS
  // pins, so it stays armed while the transceiver is off. [RULE_13]
  assign wake_event = pin_level[PIN_USB_EV] ||
                      (next_pin_level[PIN_VBUS] != pin_level[PIN_VBUS]);
  // Software setting suspend wins over a wake in the same cycle.
  assign next_suspend = (wr_ctrl && sfr_wdata_in[HF_SUSP_BIT]) ? 1'b1 :
                        (wake_event ? 1'b0 : hf_osc_suspend);  // [RULE_12]

  assign sys_from_hf = (system_clock_source_field == SYS_HF_DIV) ||
                       (system_clock_source_field == SYS_HF_HALF) ||
                       (system_clock_source_field == SYS_HF_FULL);
  assign clock_stop_req = hf_osc_suspend && sys_from_hf;  // [RULE_11]

  // Fixed divide by four is hf_cnt[1]; code 00 adds eight. [RULE_08]
  assign hf_div_tap = cks_pick4({hf_cnt[1], hf_cnt[2], hf_cnt[3],
                                 hf_cnt[4]}, hf_post_divider);  // [RULE_18]
  assign lf_div_tap = cks_pick4({lf_cnt[2], lf_cnt[1], lf_cnt[0],
                                 pin_level[PIN_LF]}, lf_osc_divider_in);

  // System clock candidates by source code; unused codes stay low.
  assign sys_if.sel  = system_clock_source_field;
  assign sys_if.cand[SYS_HF_DIV]  = hf_div_tap;           // [RULE_05]
  assign sys_if.cand[SYS_EXT]     = pin_level[PIN_EXT];   // [RULE_05]
  assign sys_if.cand[SYS_HF_HALF] = hf_cnt[0];            // [RULE_05]
  assign sys_if.cand[SYS_HF_FULL] = pin_level[PIN_HF];    // [RULE_05]
  assign sys_if.cand[SYS_LF]      = lf_div_tap;           // [RULE_06]
  assign sys_if.cand[7:5]         = 3'h0;

  // USB clock candidates; the reserved code is a stopped clock.
  assign usb_if.sel  = usb_clock_source_field;
  assign usb_if.cand[USB_HF]       = pin_level[PIN_HF];   // [RULE_01]
  assign usb_if.cand[USB_HF_DIV8]  = hf_cnt[2];           // [RULE_01]
  assign usb_if.cand[USB_EXT_DIV1] = pin_level[PIN_EXT];  // [RULE_02]
  assign usb_if.cand[USB_EXT_DIV2] = ext_cnt[0];          // [RULE_02]
  assign usb_if.cand[USB_EXT_DIV3] = (ext_div3_cnt == DIV3_LAST);
  assign usb_if.cand[USB_EXT_DIV4] = ext_cnt[1];          // [RULE_02]
  assign usb_if.cand[USB_LF]       = pin_level[PIN_LF];   // [RULE_01]
  assign usb_if.cand[USB_RESERVED] = 1'b0;                // [RULE_23]

  assign sys_mux_clk   = sys_if.clk;
  assign usb_mux_clk   = usb_if.clk;
  assign usb_clock_out = usb_mux_clk;

  // Ready mirrors the run output; bits 4:2 read as zero.
  assign ctrl_view = {hf_osc_enable, hf_osc_run_out, hf_osc_suspend,
                      3'h0, hf_post_divider};
  // Unmapped addresses read as zero.
  assign next_rdata =
    (sfr_addr_in == ADDR_CLK_SEL)  ? {1'b0, clock_source_select} :
    (sfr_addr_in == ADDR_HF_CTRL)  ? ctrl_view :
    (sfr_addr_in == ADDR_HF_CALIB) ? {1'b0, hf_osc_calibration} :
    8'h00;  // [RULE_03] [RULE_17]

  cks_glitchless_mux u_sys_mux (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .mux_if     (sys_if)
  );

  cks_glitchless_mux u_usb_mux (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .mux_if     (usb_if)
  );

  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_s1   <= '0;
      sync_s2   <= '0;
      sync_s3   <= '0;
      pin_level <= '0;
    end else begin
      sync_s1   <= raw_pins;
      sync_s2   <= sync_s1;
      sync_s3   <= sync_s2;
      pin_level <= next_pin_level;
    end
  end

  // Clock select register; bit 7 is never stored.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clock_source_select <= CLK_SEL_RST[6:0];  // [RULE_07]
    end else if (wr_sel) begin
      clock_source_select <= sfr_wdata_in[6:0];  // [RULE_03]
    end
  end

  // Oscillator control register.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hf_osc_enable   <= HF_EN_RST;
      hf_osc_suspend  <= HF_SUSP_RST;
      hf_post_divider <= HF_DIV_RST;  // [RULE_09]
    end else begin
      hf_osc_suspend <= next_suspend;  // [RULE_10]
      if (wr_ctrl) begin
        hf_osc_enable   <= sfr_wdata_in[HF_EN_BIT];  // [RULE_21]
        hf_post_divider <= sfr_wdata_in[HF_DIV_LSB +: 2];
      end
    end
  end

  // Calibration: the strap is taken on the first edge after release,
  // since an asynchronous reset may only load a constant.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hf_osc_calibration <= HF_CALIB_RST;
      trim_loaded        <= 1'b0;
    end else begin
      trim_loaded <= 1'b1;
      if (!trim_loaded) begin
        hf_osc_calibration <= factory_trim_in;  // [RULE_15]
      end else if (wr_calib) begin
        hf_osc_calibration <= sfr_wdata_in[6:0];  // [RULE_14] [RULE_17]
      end
    end
  end

  // Oscillator run and period outputs, and the read data register.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hf_osc_run_out    <= 1'b0;
      hf_osc_period_out <= HF_CALIB_RST;
      sfr_rdata_out     <= 8'h00;
    end else begin
      hf_osc_run_out    <= hf_osc_enable && !next_suspend;  // [RULE_10]
      hf_osc_period_out <= hf_osc_calibration;  // [RULE_14]
      sfr_rdata_out     <= next_rdata;
    end
  end

  // Divider counters; a halted oscillator simply stops them.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hf_cnt       <= 5'h00;
      ext_cnt      <= 2'h0;
      ext_div3_cnt <= 2'h0;
      lf_cnt       <= 3'h0;
    end else begin
      if (pin_rise[PIN_HF]) begin
        hf_cnt <= hf_cnt + 5'h01;
      end
      if (pin_rise[PIN_EXT]) begin
        ext_cnt      <= ext_cnt + 2'h1;
        ext_div3_cnt <= (ext_div3_cnt == DIV3_LAST) ? 2'h0 :
                        ext_div3_cnt + 2'h1;  // [RULE_02]
      end
      if (pin_rise[PIN_LF]) begin
        lf_cnt <= lf_cnt + 3'h1;
      end
    end
  end

  // The gate moves only while the system clock is low, so stopping and
  // resuming the CPU clock cannot clip a high phase.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cpu_gate_on <= 1'b1;
    end else if (!sys_mux_clk) begin
      cpu_gate_on <= !clock_stop_req;  // [RULE_11] [RULE_12]
    end
  end

  // System, CPU and pin clock outputs.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      system_clock_out <= 1'b0;
      cpu_clock_out    <= 1'b0;
      sys_resync       <= 1'b0;
      pin_clock_out    <= 1'b0;
    end else begin
      system_clock_out <= sys_mux_clk;
      cpu_clock_out    <= sys_mux_clk && cpu_gate_on;
      sys_resync       <= sys_mux_clk;
      pin_clock_out    <= pin_clock_out_sync_sel ? sys_resync :
                          sys_mux_clk;  // [RULE_04]
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  a_sel_bit7_zero: assert property (  // [RULE_03]
    wr_sel |=> (clock_source_select == $past(sfr_wdata_in[6:0])) ##1
               (sfr_addr_in != ADDR_CLK_SEL || !sfr_rdata_out[7]))
    else $error("clock select bit 7 not zero or write lost");
  a_calib_bit7_zero: assert property (  // [RULE_17]
    (sfr_addr_in == ADDR_HF_CALIB) |=> !sfr_rdata_out[7])
    else $error("calibration bit 7 read as one");
  a_suspend_halts: assert property (  // [RULE_10]
    (wr_ctrl && sfr_wdata_in[HF_SUSP_BIT]) |=>
      (hf_osc_suspend && !hf_osc_run_out))
    else $error("suspend write did not halt oscillator");
  a_wake_resumes: assert property (  // [RULE_12]
    (hf_osc_suspend && wake_event && !wr_ctrl) |=> !hf_osc_suspend)
    else $error("wake event did not clear suspend");
  a_cpu_clock_stop: assert property (  // [RULE_11]
    (clock_stop_req && !sys_mux_clk) |=> !cpu_clock_out [*2])
    else $error("cpu clock ran while stopped");
  a_div_field_store: assert property (  // [RULE_18]
    wr_ctrl |=> (hf_post_divider == $past(sfr_wdata_in[1:0])) &&
                (hf_osc_enable == $past(sfr_wdata_in[HF_EN_BIT])))
    else $error("oscillator control write not stored");
  a_default_div8_tap: assert property (  // [RULE_09]
    (hf_post_divider == HF_DIV_RST) |-> (sys_if.cand[SYS_HF_DIV] ==
                                          hf_cnt[4]))
    else $error("default divider is not eight after four");
  a_usb_div8_tap: assert property (  // [RULE_01]
    $rose(hf_cnt[2]) |-> $past(hf_cnt[1:0]) == 2'h3)
    else $error("usb divide by eight tap misaligned");
  a_ext_div3_range: assert property (  // [RULE_02]
    ext_div3_cnt != 2'h3)
    else $error("divide by three counter left its range");
  a_trim_capture: assert property (  // [RULE_15]
    !trim_loaded |=> hf_osc_calibration == $past(factory_trim_in))
    else $error("factory trim not captured after reset");
  a_pin_resync: assert property (  // [RULE_04]
    $past(pin_clock_out_sync_sel) |-> pin_clock_out ==
                                      $past(sys_mux_clk, 2))
    else $error("resynced pin clock wrong");

  c_suspend_entry: cover property (clock_stop_req ##1 !cpu_clock_out);
  c_wake: cover property (hf_osc_suspend ##1 !hf_osc_suspend);
  c_usb_reserved: cover property (usb_clock_source_field == USB_RESERVED);
  c_pin_sync: cover property (pin_clock_out_sync_sel && pin_clock_out);
endmodule
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cks_pkg::*;
  // Bench drives, design answers.
  logic       sys_clk_in, resetn_in, sfr_wr_in, hf, lf, ext, usb_ev, vbus;
  logic [7:0] addr, wdata, rdata, v, a;
  logic [1:0] lf_div;
  logic [6:0] trim, period_o;
  logic       run, sys_o, cpu_o, usb_o, pin_o;
  int         failures, n_compared, p, c, d, k, t, src_n;

  cks_clock_select i_dut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(sfr_wr_in),
    .sfr_rdata_out(rdata), .hf_osc_clk_in(hf), .lf_osc_clk_in(lf),
    .ext_osc_clk_in(ext), .usb_event_in(usb_ev), .vbus_sense_in(vbus),
    .lf_osc_divider_in(lf_div), .factory_trim_in(trim),
    .hf_osc_run_out(run), .hf_osc_period_out(period_o),
    .system_clock_out(sys_o), .cpu_clock_out(cpu_o),
    .usb_clock_out(usb_o), .pin_clock_out(pin_o));

  // System clock of 8 ns.
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  // Sources toggle on whole counts of the clock, by non-blocking
  // assignment at its rising edge, so periods come out exact.
  // The HF source only toggles while the design lets it run.
  initial begin
    hf = 1'b0;
    ext = 1'b0;
    lf = 1'b0;
    src_n = 0;
    forever begin
      @(posedge sys_clk_in);
      src_n++;
      if (src_n % 8 == 0 && run === 1'b1) hf <= ~hf;
      if (src_n % 10 == 0) ext <= ~ext;
      if (src_n % 14 == 0) lf <= ~lf;
    end
  end

  // Expected system clock period in clock cycles; zero means held low.
  function automatic int sys_per(int code, int dv, int ld);
    case (code)
      0: return 64 * (8 >> dv);
      1: return 20;
      2: return 32;
      3: return 16;
      4: return 28 << ld;
      default: return 0;
    endcase
  endfunction
  // Expected USB clock period in clock cycles.
  function automatic int usb_per(int code);
    case (code)
      0: return 16;
      1: return 128;
      6: return 28;
      7: return 0;
      default: return 20 * (code - 1);
    endcase
  endfunction
  function automatic logic pick(int idx);
    case (idx)
      0: return sys_o;
      1: return usb_o;
      2: return pin_o;
      default: return cpu_o;
    endcase
  endfunction

  // Verdict and end of run, reached from every path.
  task automatic conclude();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge sys_clk_in);
    addr      <= ad;
    wdata     <= dt;
    sfr_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    sfr_wr_in <= 1'b0;
  endtask
  // Read data is registered, so it is taken one edge after the address.
  task automatic rc(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge sys_clk_in);
    addr <= ad;
    @(posedge sys_clk_in);
    #1;
    chk(rdata, exp);
  endtask
  // Period between the second and third rising edge, skipping the switch.
  // With exp of zero and fewer than three rising edges seen, the count of rising edges is returned instead.
  task automatic per(input int idx, input int exp, output int pr);
    int r, t2, n;
    logic prv, cur;
    pr = 0;
    r = 0;
    t2 = 0;
    prv = pick(idx);
    for (n = 0; n < 3000 && r < 3; n++) begin
      @(posedge sys_clk_in);
      #1;
      cur = pick(idx);
      if (cur === 1'b1 && prv === 1'b0) begin
        r++;
        if (r == 2) t2 = n;
        if (r == 3) pr = n - t2;
      end
      prv = cur;
    end
    if (r < 3 && exp != 0) begin
      failures++;
      $display("ERROR t=%0t clock %0d never settled", $time, idx);
      conclude();
    end
    if (r < 3) pr = r;
  endtask

  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    sfr_wr_in = 1'b0;
    resetn_in = 1'b0;
    usb_ev = 1'b0;
    vbus = 1'b0;
    lf_div = 2'h0;
    failures = 0;
    n_compared = 0;
    void'($urandom(58));
    trim = 7'($urandom());
    repeat (16) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    // Defaults after reset: HF path, divide by eight, trim loaded.
    rc(ADDR_CLK_SEL, 8'h00);
    rc(ADDR_HF_CTRL, 8'hC0);
    rc(ADDR_HF_CALIB, {1'b0, trim});
    chk(period_o, trim);
    per(0, 512, p);
    chk(p, 512);
    // Every post divider code on the divided HF path.
    for (d = 0; d < 4; d++) begin
      wr(ADDR_HF_CTRL, {6'h20, 2'(d)});
      per(0, sys_per(0, d, 0), p);
      chk(p, sys_per(0, d, 0));
    end
    // Every system and USB code, with random junk in bit 7.
    for (c = 0; c < 8; c++) begin
      v = 8'($urandom());
      // Both pin clock variants are taken in turn.
      wr(ADDR_CLK_SEL, {v[7], 3'(c), c[0], 3'(c)});
      rc(ADDR_CLK_SEL, {1'b0, 3'(c), c[0], 3'(c)});
      // A switch waits for the old source to sit low; let it finish so
      // a last edge of the old source is not counted as a new one.
      repeat (40) @(posedge sys_clk_in);
      #1;
      per(0, sys_per(c, 3, 0), p);
      chk(p, sys_per(c, 3, 0));
      per(1, usb_per(c), p);
      chk(p, usb_per(c));
      per(2, sys_per(c, 3, 0), p);
      chk(p, sys_per(c, 3, 0));
    end
    // LF source through each of its divider codes.
    for (d = 0; d < 4; d++) begin
      @(posedge sys_clk_in);
      lf_div <= 2'(d);
      wr(ADDR_CLK_SEL, 8'h04);
      per(0, sys_per(4, 0, d), p);
      chk(p, sys_per(4, 0, d));
    end
    // Calibration is changed only with the oscillator disabled.
    wr(ADDR_HF_CTRL, 8'h03);
    rc(ADDR_HF_CTRL, 8'h03);
    chk(run, 32'h0);
    v = 8'($urandom()) | 8'h80;
    wr(ADDR_HF_CALIB, v);
    rc(ADDR_HF_CALIB, v & 8'h7F);
    chk(period_o, v[6:0]);
    wr(ADDR_HF_CTRL, 8'h83);
    wr(ADDR_CLK_SEL, 8'h03);
    // Suspend, then wake by USB event and by a VBUS edge.
    for (k = 0; k < 2; k++) begin
      wr(ADDR_HF_CTRL, 8'hA3);
      rc(ADDR_HF_CTRL, 8'hA3);
      chk(run, 32'h0);
      per(3, 0, p);
      chk(p, 32'h0);
      @(posedge sys_clk_in);
      if (k == 0) usb_ev <= 1'b1;
      else vbus <= ~vbus;
      for (t = 0; t < 40 && run !== 1'b1; t++) begin
        @(posedge sys_clk_in);
        #1;
      end
      chk(run, 32'h1);
      if (run !== 1'b1) conclude();
      @(posedge sys_clk_in);
      usb_ev <= 1'b0;
      rc(ADDR_HF_CTRL, 8'hC3);
      per(3, 16, p);
      chk(p, 16);
    end
    // Unmapped places read zero whatever is written there.
    repeat (4) begin
      a = 8'($urandom());
      if (a == ADDR_CLK_SEL || a == ADDR_HF_CTRL || a == ADDR_HF_CALIB)
        a = a ^ 8'h10;
      wr(a, 8'($urandom()));
      rc(a, 8'h00);
    end
    // A second reset in mid-run brings back the defaults.
    @(posedge sys_clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rc(ADDR_CLK_SEL, 8'h00);
    per(0, 512, p);
    chk(p, 512);
    conclude();
  end
endmodule
`default_nettype wire
